// [src/sdirx_datapath.v]
`include "sdirx_map.vh"

// Contract
// - NRZI to NRZ, then x9+x4+1 descramble
// - Ten-bit SD words, twenty-bit HD words
// - Serial bits enter words LSB first
// - De-dither stage used only when enabled
// - Separate enable for vertical blanking de-dither
// - Both de-dither enables off after reset
// - Sync sequences found and words aligned
// - Aligned words retimed to word clock
// - Sync words 000h to 003h become 000h
// - Sync words 3FCh to 3FFh become 3FFh
// - Clipping follows descramble and de-dither
// - Format detection runs only after lock
// - Detected standard readable in status register
// - Forced format code fixes single format while both restrict bits are clear; a set restrict bit overrides it
// - Restrict bits limit to SD or HD
// - Both restricts clear with format code 00h means automatic detection
// - Output FIFO depth zero to four words
// - EAV, SAV, NEW_SYNC_POSITION_FLAG taken at FIFO input
// - HD luma high ten, chroma low ten
// - SD stream low ten, duplicated high
// - Word clock matches serial rate divided
// - Output word stable between word-clock falls
module sdirx_datapath (
  input wire pclk,
  input wire presetn,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output wire pready,
  output wire pslverr,
  input wire serial_video_in,
  input wire serial_bit_valid,
  input wire cdr_lock_in,
  output wire [19:0] parallel_video_out,
  output reg word_rate_clock_out,
  output wire rate_sel_hd
);

  // ================================================================
  // Functions
  function is_hd_code;
    input [4:0] code;
    begin
      is_hd_code = code[`SDIRX_FMT_CODE_HI];
    end
  endfunction

  function near_low;
    input [9:0] s;
    begin
      near_low = (s[9:2] == 8'h00);
    end
  endfunction

  function near_high;
    input [9:0] s;
    begin
      near_high = (s[9:2] == 8'hff);
    end
  endfunction

  // ================================================================
  // Registers
  reg lsb_smoothing_undo_on_q;
  reg vblank_smoothing_undo_on_q;
  reg [4:0] forced_code_q;
  reg standard_def_restrict_q;
  reg high_def_restrict_q;
  reg [2:0] depth_q;
  reg eav_q;
  reg sav_q;
  reg new_sync_position_flag_q;
  reg det_hd_q;
  reg [4:0] sd_pend_q;
  reg lk1_q;
  reg lk2_q;
  reg lk3_q;
  reg locked_q;

  wire wr_en;
  wire rd_setup;
  wire mapped;
  wire nsp_set;
  wire nsp_clr;
  wire hd_mode;
  wire [4:0] cur_code;

  assign wr_en = psel & penable & pwrite;
  assign rd_setup = psel & ~penable & ~pwrite;
  assign mapped = (paddr == `SDIRX_OFS_VIDEO_PROC_CFG) | (paddr == `SDIRX_OFS_FORMAT_CFG) |
                  (paddr == `SDIRX_OFS_AUX_CFG_ZERO) | (paddr == `SDIRX_OFS_STATUS);
  assign pready = 1'b1;
  assign pslverr = psel & penable & ~mapped;
  assign nsp_clr = wr_en & (paddr == `SDIRX_OFS_STATUS) & pwdata[`SDIRX_ST_NSP];

  // ================================================================
  // APB slave
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lsb_smoothing_undo_on_q <= 1'b0;
      vblank_smoothing_undo_on_q <= 1'b0;
      forced_code_q <= `SDIRX_AUTO_CODE;
      standard_def_restrict_q <= 1'b0;
      high_def_restrict_q <= 1'b0;
      depth_q <= `SDIRX_RST_DEPTH;
    end else if (wr_en) begin
      case (paddr)
        `SDIRX_OFS_VIDEO_PROC_CFG: begin
          lsb_smoothing_undo_on_q <= pwdata[`SDIRX_BIT_DEDITHER];
          vblank_smoothing_undo_on_q <= pwdata[`SDIRX_BIT_VDEDITHER];
        end
        `SDIRX_OFS_FORMAT_CFG: begin
          forced_code_q <= pwdata[`SDIRX_FMT_CODE_HI:0];
          standard_def_restrict_q <= pwdata[`SDIRX_BIT_SD_RESTRICT];
          high_def_restrict_q <= pwdata[`SDIRX_BIT_HD_RESTRICT];
        end
        `SDIRX_OFS_AUX_CFG_ZERO: begin
          depth_q <= pwdata[`SDIRX_DEPTH_HI:0];
        end
        default: begin
          depth_q <= depth_q;
        end
      endcase
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (rd_setup) begin
      case (paddr)
        `SDIRX_OFS_VIDEO_PROC_CFG:
          prdata <= {30'h00000000, vblank_smoothing_undo_on_q, lsb_smoothing_undo_on_q};
        `SDIRX_OFS_FORMAT_CFG:
          prdata <= {25'h0000000, high_def_restrict_q, standard_def_restrict_q, forced_code_q};
        `SDIRX_OFS_AUX_CFG_ZERO:
          prdata <= {29'h00000000, depth_q};
        `SDIRX_OFS_STATUS:
          prdata <= {19'h00000, cur_code, 3'h0, hd_mode, locked_q,
                     new_sync_position_flag_q, sav_q, eav_q};
        default:
          prdata <= 32'h00000000;
      endcase
    end
  end

  // ================================================================
  // Lock input synchroniser
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lk1_q <= 1'b0;
      lk2_q <= 1'b0;
      lk3_q <= 1'b0;
      locked_q <= 1'b0;
    end else begin
      lk1_q <= cdr_lock_in;
      lk2_q <= lk1_q;
      lk3_q <= lk2_q;
      if (lk2_q == lk3_q) begin
        locked_q <= lk3_q;
      end
    end
  end

  // ================================================================
  // Format selection
  assign hd_mode = standard_def_restrict_q ? 1'b0 :
                   high_def_restrict_q ? 1'b1 :
                   (forced_code_q != `SDIRX_AUTO_CODE) ? is_hd_code(forced_code_q) :
                   det_hd_q;
  assign cur_code = (forced_code_q != `SDIRX_AUTO_CODE) ? forced_code_q :
                    (hd_mode ? `SDIRX_DET_HD_CODE : `SDIRX_DET_SD_CODE);
  assign rate_sel_hd = hd_mode;

  // ================================================================
  // Serial decode
  reg nrzi_prev_q;
  reg [8:0] scr_q;
  reg [59:0] hist_q;
  reg [4:0] bit_cnt_q;
  wire nrz;
  wire dsc;
  wire [59:0] hist_d;
  wire sd_match;
  wire hd_match;
  wire trs_hit;
  wire [4:0] wlen;
  wire word_end;
  wire [4:0] bit_cnt_d;

  assign nrz = serial_video_in ^ nrzi_prev_q;
  assign dsc = nrz ^ scr_q[3] ^ scr_q[8];
  assign hist_d = {dsc, hist_q[59:1]};
  assign sd_match = hist_d[59:30] == {`SDIRX_SYNC_LO, `SDIRX_SYNC_LO, `SDIRX_SYNC_HI};
  assign hd_match = hist_d == {`SDIRX_SYNC_LO, `SDIRX_SYNC_LO, `SDIRX_SYNC_LO,
                               `SDIRX_SYNC_LO, `SDIRX_SYNC_HI, `SDIRX_SYNC_HI};
  assign trs_hit = hd_mode ? hd_match : sd_match;
  assign wlen = hd_mode ? `SDIRX_HD_BITS : `SDIRX_SD_BITS;
  assign word_end = serial_bit_valid & ((bit_cnt_q >= wlen - 5'h01) | trs_hit);
  assign bit_cnt_d = word_end ? 5'h00 : bit_cnt_q + 5'h01;
  assign nsp_set = word_end & trs_hit & (bit_cnt_q != wlen - 5'h01);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      nrzi_prev_q <= 1'b0;
      scr_q <= 9'h000;
      hist_q <= 60'h000000000000000;
      bit_cnt_q <= 5'h00;
      word_rate_clock_out <= 1'b0;
      det_hd_q <= 1'b0;
      sd_pend_q <= 5'h00;
    end else if (serial_bit_valid) begin
      nrzi_prev_q <= serial_video_in;
      scr_q <= {scr_q[7:0], nrz};
      hist_q <= hist_d;
      bit_cnt_q <= bit_cnt_d;
      word_rate_clock_out <= (bit_cnt_d >= {1'b0, wlen[4:1]});
      if (locked_q) begin
        if (hd_match) begin
          det_hd_q <= 1'b1;
          sd_pend_q <= 5'h00;
        end else if (sd_match) begin
          sd_pend_q <= `SDIRX_SD_HOLD;
        end else if (sd_pend_q != 5'h00) begin
          sd_pend_q <= sd_pend_q - 5'h01;
          if (sd_pend_q == 5'h01) begin
            det_hd_q <= 1'b0;
          end
        end
      end
    end
  end

  // ================================================================
  // Word assembly and de-dither
  reg vblank_q;
  reg xyz_next_q;
  wire [19:0] raw_word;
  wire [19:0] dd_word;
  wire dd_apply;

  assign raw_word = hd_mode ? hist_d[59:40] : {10'h000, hist_d[59:50]};
  assign dd_apply = lsb_smoothing_undo_on_q & (~vblank_q | vblank_smoothing_undo_on_q);

  genvar ln;
  generate
    for (ln = 0; ln < 2; ln = ln + 1) begin : g_dd
      assign dd_word[ln*10+9:ln*10] = dd_apply ?
        {raw_word[ln*10+9:ln*10+1], 1'b0} : raw_word[ln*10+9:ln*10];
    end
  endgenerate

  // ================================================================
  // Sync clipping pipeline
  reg [19:0] s0_q;
  reg [19:0] s1_q;
  reg [19:0] s2_q;
  reg [2:0] trs_q;
  reg [2:0] xyz_q;
  reg [2:0] nsp_q;
  reg [19:0] fin_q;
  reg fin_xyz_q;
  reg fin_nsp_q;
  wire det;
  wire [19:0] clipped;
  wire [19:0] fin_d;

  assign det = near_high(s1_q[9:0]) & near_low(s0_q[9:0]) & near_low(dd_word[9:0]);

  generate
    for (ln = 0; ln < 2; ln = ln + 1) begin : g_clip
      assign clipped[ln*10+9:ln*10] =
        near_low(s2_q[ln*10+9:ln*10]) ? `SDIRX_SYNC_LO :
        near_high(s2_q[ln*10+9:ln*10]) ? `SDIRX_SYNC_HI :
        s2_q[ln*10+9:ln*10];
    end
  endgenerate

  assign fin_d = trs_q[2] ? clipped : s2_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s0_q <= 20'h00000;
      s1_q <= 20'h00000;
      s2_q <= 20'h00000;
      trs_q <= 3'h0;
      xyz_q <= 3'h0;
      nsp_q <= 3'h0;
      fin_q <= 20'h00000;
      fin_xyz_q <= 1'b0;
      fin_nsp_q <= 1'b0;
      xyz_next_q <= 1'b0;
      vblank_q <= 1'b0;
    end else if (word_end) begin
      s0_q <= dd_word;
      s1_q <= s0_q;
      s2_q <= s1_q;
      trs_q <= det ? 3'h7 : {trs_q[1:0], 1'b0};
      xyz_q <= {xyz_q[1:0], xyz_next_q};
      nsp_q <= {nsp_q[1:0], nsp_set};
      xyz_next_q <= det;
      if (xyz_next_q) begin
        vblank_q <= dd_word[7];
      end
      fin_q <= hd_mode ? fin_d : {fin_d[9:0], fin_d[9:0]};
      fin_xyz_q <= xyz_q[2];
      fin_nsp_q <= nsp_q[2];
    end
  end

  // ================================================================
  // Status taken at FIFO input stage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      eav_q <= 1'b0;
      sav_q <= 1'b0;
      new_sync_position_flag_q <= 1'b0;
    end else begin
      if (fin_xyz_q) begin
        eav_q <= fin_q[6];
        sav_q <= ~fin_q[6];
      end
      if (fin_nsp_q) begin
        new_sync_position_flag_q <= 1'b1;
      end else if (nsp_clr) begin
        new_sync_position_flag_q <= 1'b0;
      end
    end
  end

  // ================================================================
  // Output video FIFO
  sdirx_delay_line u_delay (
    .pclk(pclk),
    .presetn(presetn),
    .shift(word_end),
    .depth(depth_q),
    .din(fin_q),
    .dout(parallel_video_out)
  );

endmodule

// [shared/sdirx_map.vh]
`ifndef SDIRX_MAP_VH
`define SDIRX_MAP_VH

// ================================================================
// Register byte offsets
`define SDIRX_OFS_VIDEO_PROC_CFG 12'h000
`define SDIRX_OFS_FORMAT_CFG 12'h004
`define SDIRX_OFS_AUX_CFG_ZERO 12'h008
`define SDIRX_OFS_STATUS 12'h00c

// ================================================================
// Field positions
`define SDIRX_BIT_DEDITHER 0
`define SDIRX_BIT_VDEDITHER 1
`define SDIRX_FMT_CODE_HI 4
`define SDIRX_BIT_SD_RESTRICT 5
`define SDIRX_BIT_HD_RESTRICT 6
`define SDIRX_DEPTH_HI 2
`define SDIRX_ST_EAV 0
`define SDIRX_ST_SAV 1
`define SDIRX_ST_NSP 2
`define SDIRX_ST_LOCK 3
`define SDIRX_ST_HD 4
`define SDIRX_ST_FMT_LO 8

// ================================================================
// Reset values
`define SDIRX_RST_VIDEO_PROC_CFG 2'h0
`define SDIRX_RST_FORMAT_CFG 7'h00
`define SDIRX_RST_DEPTH 3'h0

// ================================================================
// Word sizes, sync words, depths, format codes
`define SDIRX_SD_BITS 5'h0a
`define SDIRX_HD_BITS 5'h14
`define SDIRX_SYNC_HI 10'h3ff
`define SDIRX_SYNC_LO 10'h000
`define SDIRX_MAX_DEPTH 3'h4
`define SDIRX_SD_HOLD 5'h14
`define SDIRX_AUTO_CODE 5'h00
`define SDIRX_DET_SD_CODE 5'h01
`define SDIRX_DET_HD_CODE 5'h10

`endif

// [src/sdirx_delay_line.v]
`include "sdirx_map.vh"

// ================================================================
// Variable-depth word delay with registered output
module sdirx_delay_line (
  input wire pclk,
  input wire presetn,
  input wire shift,
  input wire [2:0] depth,
  input wire [19:0] din,
  output reg [19:0] dout
);

  reg [19:0] stage_q [0:3];
  wire [2:0] depth_eff;

  // Out-of-range depths act as the deepest setting
  assign depth_eff = (depth > `SDIRX_MAX_DEPTH) ? `SDIRX_MAX_DEPTH : depth;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_stage
      always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          stage_q[g] <= 20'h00000;
        end else if (shift) begin
          stage_q[g] <= (g == 0) ? din : stage_q[(g == 0) ? 0 : g - 1];
        end
      end
    end
  endgenerate

  // Tap chosen by depth field
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dout <= 20'h00000;
    end else if (shift) begin
      case (depth_eff)
        3'h0: dout <= din;
        3'h1: dout <= stage_q[0];
        3'h2: dout <= stage_q[1];
        3'h3: dout <= stage_q[2];
        default: dout <= stage_q[3];
      endcase
    end
  end

endmodule

// [verif/sdirx_src_model.sv]
// ==========
// Serial source: scramble, NRZI, LSB first
module sdirx_src_model (
  input wire pclk,
  input wire presetn,
  input wire slow,
  output logic serial_video_in,
  output logic serial_bit_valid,
  output logic mark_q
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [25:0] q[$];
  logic [8:0] hist_q;
  logic [4:0] idx_q;
  logic lvl_q, ph_q, sc, last;
  task automatic push(input logic m, input logic [4:0] n, input logic [19:0] w);
    q.push_back({m, n, w});
  endtask
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      hist_q <= 9'h000;
      idx_q <= 5'h00;
      {lvl_q, ph_q, serial_video_in, serial_bit_valid, mark_q} <= 5'h00;
    end else begin
      ph_q <= ~ph_q;
      if (q.size() != 0 && !(slow && ph_q)) begin
        sc = q[0][idx_q] ^ hist_q[3] ^ hist_q[8];
        last = idx_q == q[0][24:20] - 5'h01;
        hist_q <= {hist_q[7:0], sc};
        lvl_q <= lvl_q ^ sc;
        serial_video_in <= lvl_q ^ sc;
        serial_bit_valid <= 1'b1;
        mark_q <= q[0][25] && last;
        idx_q <= last ? 5'h00 : idx_q + 5'h01;
        if (last) begin
          void'(q.pop_front());
        end
      end else begin
        serial_video_in <= ~serial_video_in;
        serial_bit_valid <= 1'b0;
        mark_q <= 1'b0;
      end
    end
  end
endmodule

// [verif/sdirx_asserts.sv]
module sdirx_asserts (
  input wire pclk,
  input wire presetn,
  input wire [11:0] paddr,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire serial_bit_valid,
  input wire [19:0] parallel_video_out,
  input wire word_rate_clock_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire hit = paddr == 12'h000 || paddr == 12'h004 || paddr == 12'h008 || paddr == 12'h00c;
  logic [4:0] bits_q;
  logic wclk_q;
  // ==========
  // Bits since last word
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bits_q <= 5'h00;
      wclk_q <= 1'b0;
    end else begin
      wclk_q <= word_rate_clock_out;
      if (wclk_q && !word_rate_clock_out) begin
        bits_q <= {4'h0, serial_bit_valid};
      end else if (serial_bit_valid) begin
        bits_q <= bits_q + 5'h01;
      end
    end
  end
  sequence bad_setup_s;
    psel && !penable && !hit;
  endsequence
  sequence access_s;
    psel && penable;
  endsequence
  // ==========
  // Checks
  pready_high_a: assert property (pready)
    else $error("pready low");
  bad_addr_a: assert property (bad_setup_s ##1 access_s |-> pslverr)
    else $error("no error on unmapped");
  good_addr_a: assert property (psel && penable && hit |-> !pslverr)
    else $error("error on mapped");
  err_idle_a: assert property (!(psel && penable) |-> !pslverr)
    else $error("error outside access");
  rdata_hold_a: assert property ($changed(prdata) |-> $past(psel && !penable && !pwrite))
    else $error("read data moved");
  word_hold_a: assert property ($changed(parallel_video_out) |-> $fell(word_rate_clock_out))
    else $error("word moved off clock fall");
  wclk_bit_a: assert property ($changed(word_rate_clock_out) |-> $past(serial_bit_valid))
    else $error("word clock off bit strobe");
  word_len_a: assert property (bits_q <= 5'h14)
    else $error("word too long");
endmodule
bind sdirx_datapath sdirx_asserts u_chk (
  .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
  .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .serial_bit_valid(serial_bit_valid), .parallel_video_out(parallel_video_out),
  .word_rate_clock_out(word_rate_clock_out)
);

// [verif/testbench.sv]
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic lock = 1'b0, slow = 1'b0, e, mkd, started = 1'b0, prev_w = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, r, seed = 32'hf69c9c83;
  logic [19:0] expq[$];
  logic [2:0] dtab[6] = '{3'h0, 3'h3, 3'h7, 3'h4, 3'h5, 3'h1};
  wire [31:0] prdata;
  wire [19:0] pvo;
  wire pready, pslverr, sv, sbv, mk, wclk, hd_sel;
  int bad_count = 0, compares = 0, lat = 0, eff = 0, j;
  always #4 pclk = ~pclk;
  sdirx_datapath u_dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .serial_video_in(sv), .serial_bit_valid(sbv), .cdr_lock_in(lock),
    .parallel_video_out(pvo), .word_rate_clock_out(wclk), .rate_sel_hd(hd_sel)
  );
  sdirx_src_model u_src (
    .pclk(pclk), .presetn(presetn), .slow(slow), .serial_video_in(sv),
    .serial_bit_valid(sbv), .mark_q(mk)
  );
  // ==========
  // Helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic report_and_stop();
    if (bad_count == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n = 0;
    @(posedge pclk);
    {psel, penable, pwrite, paddr, pwdata} <= {2'b10, w, a, d};
    @(posedge pclk);
    penable <= 1'b1;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    r = prdata;
    e = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 50) begin
      bad_count++;
      report_and_stop();
    end
  endtask
  // ==========
  // One line of video per pass
  task automatic run_pass(input int p);
    logic hd, dd;
    logic [4:0] nb;
    logic [19:0] pre, x, w;
    int n;
    hd = p >= 4;
    dd = p != 0 && p != 5 && p != 2;
    eff = dtab[p] > 3'h4 ? 4 : int'(dtab[p]);
    nb = hd ? 5'h14 : 5'h0a;
    pre = hd ? 20'h80200 : 20'h00200;
    x = (p == 2 || p == 3) ? 20'hab2ac : 20'h80200;
    slow <= p[0];
    apb(1, 12'h000, {30'h0, p == 3, p != 0 && p != 5});
    apb(1, 12'h004, hd ? (p == 5 ? 32'h0 : 32'h40) : 32'h20);
    apb(1, 12'h008, {29'h0, dtab[p]});
    started = 1'b0;
    // Exact sync first: realigns in pass 0, selects HD by detection in pass 5
    if (p == 0 || p == 5) begin
      if (p == 0) u_src.push(0, 5'h03, 20'h0);
      u_src.push(0, nb, hd ? 20'hfffff : 20'h003ff);
      u_src.push(0, nb, 20'h00000);
      u_src.push(0, nb, 20'h00000);
      repeat (12) u_src.push(0, nb, pre);
      n = 0;
      while (u_src.q.size() != 0 && n < 20000) begin
        @(posedge pclk);
        n++;
      end
      if (n >= 20000) begin
        bad_count++;
        report_and_stop();
      end
      repeat (500) @(posedge pclk);
    end
    repeat (4) u_src.push(0, nb, pre);
    u_src.push(1, nb, hd ? 20'hff3fe : 20'h003fe);
    u_src.push(0, nb, hd ? 20'h00802 : 20'h00002);
    u_src.push(0, nb, hd ? 20'h00403 : 20'h00001);
    u_src.push(0, nb, hd ? x : {10'h0, x[9:0]});
    expq = '{20'hfffff, 20'h00000, 20'h00000, hd ? x : {x[9:0], x[9:0]}};
    for (n = 0; n < 6; n++) begin
      seed = xs(seed);
      w = {10'h004 + 10'(seed[31:16] % 16'h03f8), 10'h004 + 10'(seed[15:0] % 16'h03f8)};
      w = hd ? w : {10'h0, w[9:0]};
      u_src.push(0, nb, w);
      w = dd ? w & 20'hffbfe : w;
      expq.push_back(hd ? w : {w[9:0], w[9:0]});
    end
    repeat (12) u_src.push(0, nb, pre);
    n = 0;
    while ((expq.size() != 0 || u_src.q.size() != 0) && n < 20000) begin
      @(posedge pclk);
      n++;
    end
    if (n >= 20000) begin
      bad_count++;
      report_and_stop();
    end
    check(hd_sel, hd);
  endtask
  // ==========
  // Output watcher
  always @(posedge pclk) begin
    mkd = sbv && mk;
    #1;
    if (mkd) lat = 0;
    else if (prev_w && !wclk) lat++;
    if (prev_w && !wclk && expq.size() != 0) begin
      if (!started && pvo === 20'hfffff) begin
        started = 1'b1;
        check(lat, 4 + eff);
      end
      if (started) check(pvo, expq.pop_front());
    end
    prev_w = wclk;
  end
  // ==========
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    for (j = 0; j < 3; j++) begin
      apb(0, 12'(4 * j), 32'h0);
      check(r, 32'h0);
    end
    apb(0, 12'h010, 32'h0);
    check({r[30:0], e}, 32'h1);
    apb(0, 12'h00c, 32'h0);
    check(r[3], 1'b0);
    lock <= 1'b1;
    repeat (8) @(posedge pclk);
    for (j = 0; j < 6; j++) begin
      run_pass(j);
      apb(0, 12'h00c, 32'h0);
      check(r[4:3], {j >= 4, 1'b1});
      if (j == 0) begin
        check(r[2], 1'b1);
        apb(1, 12'h00c, 32'h4);
        apb(0, 12'h00c, 32'h0);
        check(r[2], 1'b0);
      end
    end
    check(r[12:8], 5'h10);
    for (j = 0; j < 2; j++) begin
      apb(1, 12'h004, j ? 32'h12 : 32'h03);
      apb(0, 12'h00c, 32'h0);
      check({hd_sel, r[12:8]}, j ? 6'h32 : 6'h03);
    end
    apb(1, 12'h004, 32'h32);
    apb(0, 12'h000, 32'h0);
    check(hd_sel, 1'b0);
    report_and_stop();
  end
endmodule
